// *** rtl/occ_consts.svh ***
// register offsets, field positions and reset values of the output compare unit
// Operation
// - continuously compare value against selected timer
// - match drives pin high, low, toggle, unchanged
// - interrupt flag set with the pin action
// - clearing control forces compare latch low
// - matching valid only for synchronous timer modes
// - software interrupt mode leaves pin untouched
// - special event mode pulses internal trigger
// - trigger resets the selected timer pair
// - trigger never starts a conversion
// - compare output overrides port data latch
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH

// ==========================================
// register byte offsets
`define OCC_OFS_CTRL   5'h00
`define OCC_OFS_VALUE  5'h04
`define OCC_OFS_TSEL   5'h08
`define OCC_OFS_STAT   5'h0C
`define OCC_OFS_MASK   5'h10
`define OCC_OFS_PORT   5'h14

// ==========================================
// field positions
`define OCC_STAT_MATCH 0
`define OCC_STAT_TRIG  1
`define OCC_PORT_DIR   0
`define OCC_PORT_LAT   1
`define OCC_PORT_PIN   2
`define OCC_PORT_CMP   3

// ==========================================
// reset values
`define OCC_RST_CTRL   4'h0
`define OCC_RST_VALUE  16'h0000
`define OCC_RST_TSEL   2'h0
`define OCC_RST_STAT   2'h0
`define OCC_RST_MASK   2'h0
`define OCC_RST_DIR    1'b1
`define OCC_RST_LAT    1'b0

`endif

// *** rtl/occ_pkg.sv ***
// types and helper functions of the output compare unit
package occ_pkg;

	// ==========================================
	// compare mode codes
	typedef enum logic [3:0] {
		OCC_MODE_OFF    = 4'h0,
		OCC_MODE_TOGGLE = 4'h2,
		OCC_MODE_HIGH   = 4'h8,
		OCC_MODE_LOW    = 4'h9,
		OCC_MODE_SWIRQ  = 4'hA,
		OCC_MODE_SPEC   = 4'hB
	} occ_mode_t;

	// ==========================================
	// bus slave states, one-hot
	typedef enum logic [1:0] {
		OCC_BUS_IDLE = 2'b01,
		OCC_BUS_ACK  = 2'b10
	} occ_bus_st_t;

	// modes that act on the pin
	function automatic logic occ_pin_mode(input logic [3:0] m);
		return (m == OCC_MODE_TOGGLE) || (m == OCC_MODE_HIGH) || (m == OCC_MODE_LOW);
	endfunction

	// every compare mode, pin acting or not
	function automatic logic occ_cmp_mode(input logic [3:0] m);
		return occ_pin_mode(m) || (m == OCC_MODE_SWIRQ) || (m == OCC_MODE_SPEC);
	endfunction

	// byte-enable merge of a write into a word
	function automatic logic [31:0] occ_wmerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// *** rtl/occ_match.sv ***
// equality detector between compare value and the selected timer pair
`timescale 1ns/1ns
module occ_match
	import occ_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// timer pairs
	input  wire logic [15:0] timer0_val,
	input  wire logic [15:0] timer1_val,
	input  wire logic [15:0] timer2_val,
	input  wire logic [15:0] timer3_val,
	input  wire logic [3:0]  timer_async,
	// configuration
	input  wire logic [1:0]  tsel,
	input  wire logic [15:0] cmp_val,
	// result
	output logic             match_q
);

	// ==========================================
	// selection and compare
	logic [15:0] sel_val;
	logic        eq_now;
	logic        async_sel;
	logic        eq_q;

	assign sel_val = (tsel == 2'h0) ? timer0_val :
	                 (tsel == 2'h1) ? timer1_val :
	                 (tsel == 2'h2) ? timer2_val : timer3_val;
	assign eq_now    = (sel_val == cmp_val);
	// an asynchronous counter cannot be compared safely
	assign async_sel = timer_async[tsel];

	// one event per arrival at the value, not per cycle held there
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			eq_q    <= 1'b0;
			match_q <= 1'b0;
		end else begin
			eq_q    <= eq_now;
			match_q <= eq_now & ~eq_q & ~async_sel;
		end
	end

	// ==========================================
	// checks
	property p_match_seen;
		@(posedge ref_clk) disable iff (sys_rst)
		(eq_now && !eq_q && !async_sel) |=> match_q;
	endproperty
	a_match_seen: assert property (p_match_seen) else $error("match not flagged");

	property p_async_quiet;
		@(posedge ref_clk) disable iff (sys_rst)
		async_sel |=> !match_q;
	endproperty
	a_async_quiet: assert property (p_async_quiet) else $error("async timer matched");

endmodule

// *** rtl/occ_top.sv ***
// output compare unit with Avalon-MM register slave and interrupt
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`include "occ_consts.svh"
module occ_top
	import occ_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// timer pairs of the time base
	input  wire logic [15:0] timer0_val,
	input  wire logic [15:0] timer1_val,
	input  wire logic [15:0] timer2_val,
	input  wire logic [15:0] timer3_val,
	input  wire logic [3:0]  timer_async,
	// timer reset and trigger
	output logic [3:0]       timer_reset,
	output logic             special_event,
	// compare output pin
	output logic             compare_output_pin_o,
	output logic             compare_output_pin_oe_n,
	// interrupt
	output logic             irq
);

	// ==========================================
	// state
	occ_bus_st_t bus_st_q;
	occ_bus_st_t bus_st_d;
	logic        waitreq_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [3:0]  ctrl_q;
	logic [3:0]  ctrl_d;
	logic [15:0] value_q;
	logic [15:0] value_d;
	logic [1:0]  tsel_q;
	logic [1:0]  tsel_d;
	logic [1:0]  stat_q;
	logic [1:0]  stat_d;
	logic [1:0]  mask_q;
	logic [1:0]  mask_d;
	logic        dir_q;
	logic        dir_d;
	logic        lat_q;
	logic        lat_d;
	logic        cmp_latch_q;
	logic        cmp_latch_d;
	logic        pin_out_q;
	logic        pin_out_d;
	logic        pin_oe_n_q;
	logic        irq_q;
	logic        spec_q;
	logic [3:0]  treset_q;
	logic        match_q;

	// ==========================================
	// match detector
	occ_match u_match (
		.ref_clk     (ref_clk),
		.sys_rst     (sys_rst),
		.timer0_val  (timer0_val),
		.timer1_val  (timer1_val),
		.timer2_val  (timer2_val),
		.timer3_val  (timer3_val),
		.timer_async (timer_async),
		.tsel        (tsel_q),
		.cmp_val     (value_q),
		.match_q     (match_q)
	);

	// ==========================================
	// bus decode
	logic        bus_req;
	logic        bus_acc;
	logic        wr_acc;
	logic        wr_ctrl;
	logic        wr_value;
	logic        wr_tsel;
	logic        wr_stat;
	logic        wr_mask;
	logic        wr_port;
	logic [31:0] wmrg_ctrl;
	logic [31:0] wmrg_value;
	logic [31:0] wmrg_tsel;
	logic [31:0] wmrg_stat;
	logic [31:0] wmrg_mask;
	logic [31:0] wmrg_port;
	logic [31:0] port_view;

	assign bus_req  = avs_read | avs_write;
	// a write lands on the edge where the master sees waitrequest low
	assign bus_acc  = (bus_st_q == OCC_BUS_ACK);
	assign wr_acc   = bus_acc & avs_write;
	assign wr_ctrl  = wr_acc & (avs_address == `OCC_OFS_CTRL);
	assign wr_value = wr_acc & (avs_address == `OCC_OFS_VALUE);
	assign wr_tsel  = wr_acc & (avs_address == `OCC_OFS_TSEL);
	assign wr_stat  = wr_acc & (avs_address == `OCC_OFS_STAT);
	assign wr_mask  = wr_acc & (avs_address == `OCC_OFS_MASK);
	assign wr_port  = wr_acc & (avs_address == `OCC_OFS_PORT);

	assign port_view = {28'h0000000, cmp_latch_q, pin_out_q, lat_q, dir_q};

	assign wmrg_ctrl  = occ_wmerge({28'h0000000, ctrl_q}, avs_writedata, avs_byteenable);
	assign wmrg_value = occ_wmerge({16'h0000, value_q}, avs_writedata, avs_byteenable);
	assign wmrg_tsel  = occ_wmerge({30'h0, tsel_q}, avs_writedata, avs_byteenable);
	// only enabled lanes may clear a flag
	assign wmrg_stat  = occ_wmerge(32'h00000000, avs_writedata, avs_byteenable);
	assign wmrg_mask  = occ_wmerge({30'h0, mask_q}, avs_writedata, avs_byteenable);
	assign wmrg_port  = occ_wmerge(port_view, avs_writedata, avs_byteenable);

	// unmapped addresses read as zero and ignore writes
	assign rdata_d = (avs_address == `OCC_OFS_CTRL)  ? {28'h0000000, ctrl_q} :
	                 (avs_address == `OCC_OFS_VALUE) ? {16'h0000, value_q} :
	                 (avs_address == `OCC_OFS_TSEL)  ? {30'h0, tsel_q} :
	                 (avs_address == `OCC_OFS_STAT)  ? {30'h0, stat_q} :
	                 (avs_address == `OCC_OFS_MASK)  ? {30'h0, mask_q} :
	                 (avs_address == `OCC_OFS_PORT)  ? port_view : 32'h00000000;

	// ==========================================
	// bus slave state machine
	always_comb begin
		case (bus_st_q)
			OCC_BUS_IDLE: begin
				bus_st_d = bus_req ? OCC_BUS_ACK : OCC_BUS_IDLE;
			end
			OCC_BUS_ACK: begin
				bus_st_d = OCC_BUS_IDLE;
			end
			default: begin
				bus_st_d = OCC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_st_q  <= OCC_BUS_IDLE;
			waitreq_q <= 1'b1;
			rdata_q   <= 32'h00000000;
		end else begin
			bus_st_q  <= bus_st_d;
			waitreq_q <= ~(bus_st_d == OCC_BUS_ACK);
			rdata_q   <= (bus_st_d == OCC_BUS_ACK) ? rdata_d : rdata_q;
		end
	end

	// ==========================================
	// configuration registers
	logic ctrl_clr;
	logic act_mode;
	logic spec_mode;
	logic cmp_hit;

	assign ctrl_d   = wr_ctrl ? wmrg_ctrl[3:0] : ctrl_q;
	assign value_d  = wr_value ? wmrg_value[15:0] : value_q;
	assign tsel_d   = wr_tsel ? wmrg_tsel[1:0] : tsel_q;
	assign mask_d   = wr_mask ? wmrg_mask[1:0] : mask_q;
	assign dir_d    = wr_port ? wmrg_port[`OCC_PORT_DIR] : dir_q;
	assign lat_d    = wr_port ? wmrg_port[`OCC_PORT_LAT] : lat_q;
	// writing zero to control is the clear
	assign ctrl_clr = wr_ctrl & (ctrl_d == OCC_MODE_OFF);

	assign act_mode  = occ_pin_mode(ctrl_q);
	assign spec_mode = (ctrl_q == OCC_MODE_SPEC);
	assign cmp_hit   = match_q & occ_cmp_mode(ctrl_q);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q  <= `OCC_RST_CTRL;
			value_q <= `OCC_RST_VALUE;
			tsel_q  <= `OCC_RST_TSEL;
			mask_q  <= `OCC_RST_MASK;
			dir_q   <= `OCC_RST_DIR;
			lat_q   <= `OCC_RST_LAT;
		end else begin
			ctrl_q  <= ctrl_d;
			value_q <= value_d;
			tsel_q  <= tsel_d;
			mask_q  <= mask_d;
			dir_q   <= dir_d;
			lat_q   <= lat_d;
		end
	end

	// ==========================================
	// compare output latch
	always_comb begin
		cmp_latch_d = cmp_latch_q;
		if (ctrl_clr) begin
			cmp_latch_d = 1'b0;
		end else if (match_q) begin
			case (ctrl_q)
				OCC_MODE_HIGH: begin
					cmp_latch_d = 1'b1;
				end
				OCC_MODE_LOW: begin
					cmp_latch_d = 1'b0;
				end
				OCC_MODE_TOGGLE: begin
					cmp_latch_d = ~cmp_latch_q;
				end
				default: begin
					// software interrupt and trigger leave the latch alone
					cmp_latch_d = cmp_latch_q;
				end
			endcase
		end
	end

	// pin muxing: compare latch wins over port data when driven
	assign pin_out_d = (act_mode & ~dir_q) ? cmp_latch_q : lat_q;

	// ==========================================
	// status, mask and interrupt
	logic [1:0] stat_set;
	logic [1:0] stat_clr;

	assign stat_set = {cmp_hit & spec_mode, cmp_hit};
	assign stat_clr = wr_stat ? wmrg_stat[1:0] : 2'h0;
	// set beats a same-cycle clear so no event is lost
	assign stat_d   = (stat_q & ~stat_clr) | stat_set;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_latch_q <= 1'b0;
			pin_out_q   <= 1'b0;
			pin_oe_n_q  <= 1'b1;
			stat_q      <= `OCC_RST_STAT;
			irq_q       <= 1'b0;
		end else begin
			cmp_latch_q <= cmp_latch_d;
			pin_out_q   <= pin_out_d;
			// direction bit set by software; pin floats until cleared
			pin_oe_n_q  <= dir_d;
			stat_q      <= stat_d;
			irq_q       <= |(stat_d & mask_d);
		end
	end

	// ==========================================
	// special event trigger
	logic [3:0] tsel_hot;

	assign tsel_hot = 4'h1 << tsel_q;

	// trigger fans out to timer resets only; no conversion start exists
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			spec_q   <= 1'b0;
			treset_q <= 4'h0;
		end else begin
			spec_q   <= match_q & spec_mode;
			treset_q <= (match_q & spec_mode) ? tsel_hot : 4'h0;
		end
	end

	// ==========================================
	// outputs
	assign avs_readdata            = rdata_q;
	assign avs_waitrequest         = waitreq_q;
	assign timer_reset             = treset_q;
	assign special_event           = spec_q;
	assign compare_output_pin_o    = pin_out_q;
	assign compare_output_pin_oe_n = pin_oe_n_q;
	assign irq                     = irq_q;

	// ==========================================
	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_hit(logic [3:0] m);
		match_q && !ctrl_clr && (ctrl_q == m);
	endsequence

	property p_flag_with_action;
		(match_q && occ_cmp_mode(ctrl_q)) |=> stat_q[`OCC_STAT_MATCH];
	endproperty
	a_flag_with_action: assert property (p_flag_with_action) else $error("flag not set");

	property p_drive_high;
		s_hit(OCC_MODE_HIGH) |=> cmp_latch_q;
	endproperty
	a_drive_high: assert property (p_drive_high) else $error("latch not high");

	property p_drive_low;
		s_hit(OCC_MODE_LOW) |=> !cmp_latch_q;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("latch not low");

	property p_toggle;
		s_hit(OCC_MODE_TOGGLE) |=> (cmp_latch_q != $past(cmp_latch_q));
	endproperty
	a_toggle: assert property (p_toggle) else $error("latch not toggled");

	property p_swirq_quiet;
		s_hit(OCC_MODE_SWIRQ) |=> $stable(cmp_latch_q) && stat_q[`OCC_STAT_MATCH];
	endproperty
	a_swirq_quiet: assert property (p_swirq_quiet) else $error("swirq moved pin");

	property p_clear_latch;
		ctrl_clr |=> !cmp_latch_q && (ctrl_q == OCC_MODE_OFF) ##1 !cmp_latch_q;
	endproperty
	a_clear_latch: assert property (p_clear_latch) else $error("latch not cleared");

	property p_trigger_pulse;
		s_hit(OCC_MODE_SPEC) |=> spec_q && (timer_reset != 4'h0);
	endproperty
	a_trigger_pulse: assert property (p_trigger_pulse) else $error("no trigger");

	property p_reset_target;
		spec_q |-> (treset_q == (4'h1 << $past(tsel_q)));
	endproperty
	a_reset_target: assert property (p_reset_target) else $error("wrong timer reset");

	property p_pin_priority;
		(act_mode && !dir_q) |=> (pin_out_q == $past(cmp_latch_q));
	endproperty
	a_pin_priority: assert property (p_pin_priority) else $error("port won over compare");

	property p_irq_level;
		(|(stat_q & mask_q)) == irq_q;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

	property p_flag_sticky;
		(stat_q[`OCC_STAT_MATCH] && !wr_stat) |=> stat_q[`OCC_STAT_MATCH];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

endmodule

// *** tb/occ_timer_model.sv ***
// behavioural time base: four timer pairs counting in synchronous timer mode
`timescale 1ns/1ns
module occ_timer_model #(
	parameter logic [15:0] WRAP = 16'h00FF
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// reset request from the compare unit
	input  wire logic [3:0]  timer_reset,
	// timer pairs
	output logic [15:0]      timer0_val,
	output logic [15:0]      timer1_val,
	output logic [15:0]      timer2_val,
	output logic [15:0]      timer3_val
);
	logic [15:0] cnt_q [4];
	// ==========================================
	// counters
	// short wrap keeps every match within a few hundred cycles
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		for (int i = 0; i < 4; i++) begin
			if (sys_rst) begin
				cnt_q[i] <= 16'h0000;
			end else if (timer_reset[i]) begin
				cnt_q[i] <= 16'h0000;
			end else begin
				cnt_q[i] <= (cnt_q[i] == WRAP) ? 16'h0000 : cnt_q[i] + 16'h0001;
			end
		end
	end
	assign timer0_val = cnt_q[0];
	assign timer1_val = cnt_q[1];
	assign timer2_val = cnt_q[2];
	assign timer3_val = cnt_q[3];
endmodule

// *** tb/tb_output_compare_unit.sv ***
// self-checking bench of the output compare unit
`timescale 1ns/1ns
`include "occ_consts.svh"
module tb_output_compare_unit;
	import occ_pkg::*;
	logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, special_event;
	logic pin_o, pin_oe_n, irq;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable, timer_async, timer_reset;
	logic [15:0] t0, t1, t2, t3;
	int n_mismatch, num_checks, cyc;
	occ_top occ_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .timer0_val(t0), .timer1_val(t1),
		.timer2_val(t2), .timer3_val(t3), .timer_async(timer_async),
		.timer_reset(timer_reset), .special_event(special_event),
		.compare_output_pin_o(pin_o), .compare_output_pin_oe_n(pin_oe_n), .irq(irq));
	occ_timer_model occ_timer_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.timer_reset(timer_reset), .timer0_val(t0), .timer1_val(t1), .timer2_val(t2),
		.timer3_val(t3));
	// ==========================================
	// clock, timeout, helpers
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		@(negedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(negedge ref_clk);
		@(posedge ref_clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(nm, exp, q & m);
	endtask
	// waits at most n cycles for the interrupt line
	task automatic wait_irq(input int n);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < n) begin
			@(negedge ref_clk);
			k++;
		end
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		chk("irq_rst", 32'h0, irq);
		chk("oe_rst", 32'h1, pin_oe_n);
		rd_chk("ctrl", `OCC_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		rd_chk("tsel", `OCC_OFS_TSEL, 32'hFFFFFFFF, 32'h0);
		rd_chk("stat", `OCC_OFS_STAT, 32'hFFFFFFFF, 32'h0);
		rd_chk("port", `OCC_OFS_PORT, 32'h0000000B, 32'h1);
		rd_chk("unmapped", 5'h18, 32'hFFFFFFFF, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_pin_modes();
		logic [3:0] md [4];
		logic ex [4];
		// ends with the latch high so that the clear below has something to undo
		md = '{OCC_MODE_LOW, OCC_MODE_HIGH, OCC_MODE_TOGGLE, OCC_MODE_TOGGLE};
		ex = '{1'b0, 1'b1, 1'b0, 1'b1};
		wr(`OCC_OFS_PORT, 32'h2);
		wr(`OCC_OFS_VALUE, 32'h40);
		wr(`OCC_OFS_MASK, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(`OCC_OFS_CTRL, md[i]);
			wait_irq(600);
			repeat (20) @(negedge ref_clk);
			chk("irq", 32'h1, irq);
			chk("pin", ex[i], pin_o);
			chk("oe_n", 32'h0, pin_oe_n);
			rd_chk("stat", `OCC_OFS_STAT, 32'h1, 32'h1);
			wr(`OCC_OFS_STAT, 32'h3);
			repeat (2) @(negedge ref_clk);
			chk("irq_clr", 32'h0, irq);
		end
		wr(`OCC_OFS_CTRL, 32'h0);
		rd_chk("latch_clr", `OCC_OFS_PORT, 32'h0000000A, 32'h2);
		$display("test pin modes done");
	endtask
	task automatic t_swirq();
		wr(`OCC_OFS_CTRL, OCC_MODE_SWIRQ);
		wait_irq(600);
		chk("swirq", 32'h1, irq);
		repeat (2) @(negedge ref_clk);
		chk("pin_kept", 32'h1, pin_o);
		rd_chk("swirq_latch", `OCC_OFS_PORT, 32'h00000008, 32'h0);
		wr(`OCC_OFS_MASK, 32'h0);
		repeat (2) @(negedge ref_clk);
		chk("irq_masked", 32'h0, irq);
		rd_chk("swirq_flag", `OCC_OFS_STAT, 32'h1, 32'h1);
		wr(`OCC_OFS_MASK, 32'h1);
		wr(`OCC_OFS_STAT, 32'h3);
		wr(`OCC_OFS_CTRL, 32'h0);
		$display("test swirq done");
	endtask
	task automatic t_trigger();
		int k;
		k = 0;
		wr(`OCC_OFS_TSEL, 32'h2);
		wr(`OCC_OFS_VALUE, 32'h30);
		wr(`OCC_OFS_CTRL, OCC_MODE_SPEC);
		while (special_event !== 1'b1 && k < 600) begin
			@(negedge ref_clk);
			k++;
		end
		chk("trig", 32'h1, special_event);
		chk("treset", 32'h4, timer_reset);
		@(negedge ref_clk);
		chk("trig_pulse", 32'h0, special_event);
		chk("t2_small", 32'h1, t2 < 16'h0004);
		rd_chk("trig_flag", `OCC_OFS_STAT, 32'h2, 32'h2);
		wr(`OCC_OFS_CTRL, 32'h0);
		wr(`OCC_OFS_STAT, 32'h3);
		$display("test trigger done");
	endtask
	task automatic t_async();
		timer_async <= 4'h4;
		wr(`OCC_OFS_CTRL, OCC_MODE_HIGH);
		wait_irq(600);
		chk("async_irq", 32'h0, irq);
		rd_chk("async_stat", `OCC_OFS_STAT, 32'h3, 32'h0);
		timer_async <= 4'h0;
		wr(`OCC_OFS_TSEL, 32'h1);
		wait_irq(600);
		chk("tsel1_irq", 32'h1, irq);
		$display("test async done");
	endtask
	// ==========================================
	// main sequence
	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		timer_async = 4'h0;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		t_reset();
		t_pin_modes();
		t_swirq();
		t_trigger();
		t_async();
		complete_run();
	end
endmodule
